// file: hdl/reset_source_flags.sv
// reset source indication flags with avalon slave and interrupt
// ====================================================================
// What this block does
// - four flags at bits 4,3,2,1
// - long reset sets long,short,software; clears watchdog
// - short reset sets short,software; clears watchdog
// - software reset sets software flag only while the bidirectional option is off
// - watchdog reset sets software and watchdog flags
// - end of init clears three hardware/software flags
// - watchdog service clears only watchdog flag
// - bidirectional option also sets hardware flags
`timescale 1ns/100ps
module reset_source_flags
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        long_hw_reset_pin,
  input  wire logic        short_hw_reset_pin,
  input  wire logic        software_reset_instruction,
  input  wire logic        watchdog_reset_event,
  input  wire logic        end_init_instruction,
  input  wire logic        watchdog_service_instruction,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             long_hw_reset_flag,
  output logic             short_hw_reset_flag,
  output logic             software_reset_flag,
  output logic             watchdog_reset_flag,
  output logic             irq
);
  // ====================================================================
  // state
  // one register word; sets and clears meet in a single next-state pass
  typedef struct packed
  {
    logic        long_hw;
    logic        short_hw;
    logic        software;
    logic        watchdog;
    logic [5:0]  status;
    logic [5:0]  mask;
    logic        bidir;
    logic        answered;
    logic [31:0] readdata;
  } state_s;

  state_s st;
  state_s next_st;

  logic long_level;
  logic short_level;
  logic long_pulse;
  logic short_pulse;

  // ====================================================================
  // pin inputs: external reset lines cross into the clock domain
  // a held pin counts once: only its rising edge is an event
  pin_sync u_long_sync
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pin     (long_hw_reset_pin),
    .level   (long_level)
  );

  pin_sync u_short_sync
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pin     (short_hw_reset_pin),
    .level   (short_level)
  );

  rise_detect u_long_edge
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .level   (long_level),
    .pulse   (long_pulse)
  );

  rise_detect u_short_edge
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .level   (short_level),
    .pulse   (short_pulse)
  );

  // ====================================================================
  // helpers
  function automatic logic [31:0] flag_word(input state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[reset_flags_pkg::LONG_HW_POS]  = s.long_hw;
    w[reset_flags_pkg::SHORT_HW_POS] = s.short_hw;
    w[reset_flags_pkg::SOFTWARE_POS] = s.software;
    w[reset_flags_pkg::WATCHDOG_POS] = s.watchdog;
    return w;
  endfunction : flag_word

  logic       access;
  logic       wr;
  logic       rd;
  logic [5:0] events;
  logic [5:0] w1c;

  // one wait cycle per access, then an answer
  assign access = (avs_read | avs_write) & ~st.answered;
  assign wr     = avs_write & st.answered;
  assign rd     = avs_read & st.answered;
  assign events = {watchdog_service_instruction, end_init_instruction, watchdog_reset_event,
                   software_reset_instruction, short_pulse, long_pulse};
  assign w1c    = (wr && avs_address == reset_flags_pkg::IRQ_STATUS_OFFSET && avs_byteenable[0])
                  ? avs_writedata[5:0] : 6'h00;

  // ====================================================================
  // next state
  always_comb
  begin
    next_st = st;
    next_st.answered = access;
    // service and end-of-init clears come first so a set in the same cycle wins; a pin pulse clears watchdog after a watchdog event sets it
    // service clears watchdog
    if (watchdog_service_instruction)
      next_st.watchdog = 1'b0;
    if (end_init_instruction)
    begin
      next_st.long_hw  = 1'b0;
      next_st.short_hw = 1'b0;
      next_st.software = 1'b0;
    end
    if (software_reset_instruction)
    begin
      next_st.software = 1'b1;
      if (st.bidir)
      begin
        next_st.long_hw  = 1'b1;
        next_st.short_hw = 1'b1;
      end
    end
    if (watchdog_reset_event)
    begin
      next_st.software = 1'b1;
      next_st.watchdog = 1'b1;
      if (st.bidir)
      begin
        next_st.long_hw  = 1'b1;
        next_st.short_hw = 1'b1;
      end
    end
    if (short_pulse)
    begin
      next_st.short_hw = 1'b1;
      next_st.software = 1'b1;
      next_st.watchdog = 1'b0;
      if (st.bidir)
        next_st.long_hw = 1'b1;
    end
    if (long_pulse)
    begin
      next_st.long_hw  = 1'b1;
      next_st.short_hw = 1'b1;
      next_st.software = 1'b1;
      next_st.watchdog = 1'b0;
    end
    // status: set wins over write-one-to-clear
    next_st.status = (st.status & ~w1c) | events;
    if (wr && avs_byteenable[0])
    begin
      if (avs_address == reset_flags_pkg::IRQ_MASK_OFFSET)
        next_st.mask = avs_writedata[5:0];
      if (avs_address == reset_flags_pkg::OPTION_OFFSET)
        next_st.bidir = avs_writedata[0];
    end
    // read returns the addressed register (flags at offset 0), no side effect
    next_st.readdata = 32'h0000_0000;
    if (access && avs_read)
    begin
      unique case (avs_address)
        reset_flags_pkg::WATCHDOG_CONTROL_OFFSET: next_st.readdata = flag_word(st);
        reset_flags_pkg::IRQ_STATUS_OFFSET:       next_st.readdata = {26'h000_0000, st.status};
        reset_flags_pkg::IRQ_MASK_OFFSET:         next_st.readdata = {26'h000_0000, st.mask};
        reset_flags_pkg::OPTION_OFFSET:           next_st.readdata = {31'h0000_0000, st.bidir};
        default:                                  next_st.readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st          <= '0;
      st.mask     <= reset_flags_pkg::IRQ_MASK_RESET;
      st.bidir    <= reset_flags_pkg::BIDIR_RESET;
    end
    else
      st <= next_st;
  end

  // ====================================================================
  // outputs
  // flags at their bit positions
  assign long_hw_reset_flag  = st.long_hw;
  assign short_hw_reset_flag = st.short_hw;
  assign software_reset_flag = st.software;
  assign watchdog_reset_flag = st.watchdog;
  assign avs_readdata        = st.readdata;
  assign avs_waitrequest     = access;
  // level interrupt: stays up until software clears the status bit or its mask bit
  assign irq                 = |(st.status & st.mask);

  // ====================================================================
  // checks
  // pin pulses can meet instructions in one cycle; antecedents rule out only meetings that alter the result; long_reset_a needs none, long pulse wins
  sequence long_event_s;
    long_pulse;
  endsequence

  sequence long_flags_s;
    long_hw_reset_flag && short_hw_reset_flag && software_reset_flag && !watchdog_reset_flag;
  endsequence

  long_reset_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    long_event_s |=> long_flags_s)
    else $error("long reset flags wrong");

  short_reset_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    short_pulse && !long_pulse && !st.bidir && !end_init_instruction |=>
      short_hw_reset_flag && software_reset_flag && !watchdog_reset_flag
      && long_hw_reset_flag == $past(long_hw_reset_flag))
    else $error("short reset flags wrong");

  software_reset_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    software_reset_instruction && !watchdog_service_instruction && !short_pulse && !long_pulse
      && !watchdog_reset_event |=> software_reset_flag && watchdog_reset_flag == $past(watchdog_reset_flag))
    else $error("software reset flags wrong");

  watchdog_reset_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    watchdog_reset_event && !short_pulse && !long_pulse |=> software_reset_flag && watchdog_reset_flag)
    else $error("watchdog reset flags wrong");

  end_init_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    end_init_instruction && !(|events[3:0]) |=> !long_hw_reset_flag && !short_hw_reset_flag
      && !software_reset_flag && watchdog_reset_flag == $past(watchdog_reset_flag))
    else $error("end of init flags wrong");

  service_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    watchdog_service_instruction && !(|events[4:0]) |=> !watchdog_reset_flag
      && $stable({long_hw_reset_flag, short_hw_reset_flag, software_reset_flag}))
    else $error("service flags wrong");

  bidir_sets_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    st.bidir && (software_reset_instruction || watchdog_reset_event || short_pulse) |=>
      long_hw_reset_flag)
    else $error("bidirectional option ignored");

  read_still_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    avs_read && !(|events) |=> $stable(flag_word(st)))
    else $error("read altered flags");

  read_value_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    avs_read && access && avs_address == reset_flags_pkg::WATCHDOG_CONTROL_OFFSET |=>
      avs_readdata == flag_word($past(st)) && !avs_waitrequest)
    else $error("flag read value wrong");

  // ====================================================================
  // bus and interrupt checks
  // a master holds its request until it sees waitrequest low
  sequence bus_request_s;
    (avs_read || avs_write) && !st.answered;
  endsequence

  sequence bus_answer_s;
    !avs_waitrequest ##1 !st.answered;
  endsequence

  bus_answer_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    bus_request_s |-> avs_waitrequest ##1 bus_answer_s)
    else $error("bus answer timing wrong");

  wait_once_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");

  read_idle_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !avs_read |=> avs_readdata == 32'h0000_0000)
    else $error("read data not zero when idle");

  read_status_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    avs_read && access && avs_address == reset_flags_pkg::IRQ_STATUS_OFFSET |=>
      avs_readdata == {26'h000_0000, $past(st.status)})
    else $error("status read value wrong");

  control_ro_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    avs_write && avs_address == reset_flags_pkg::WATCHDOG_CONTROL_OFFSET && !(|events) |=>
      $stable(flag_word(st)))
    else $error("flag register took a write");

  mask_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr && avs_byteenable[0] && avs_address == reset_flags_pkg::IRQ_MASK_OFFSET |=>
      st.mask == $past(avs_writedata[5:0]))
    else $error("mask write lost");

  option_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr && avs_byteenable[0] && avs_address == reset_flags_pkg::OPTION_OFFSET |=>
      st.bidir == $past(avs_writedata[0]))
    else $error("option write lost");

  status_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (|events) |=> (st.status & $past(events)) == $past(events))
    else $error("event not recorded in status");

  status_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr && avs_byteenable[0] && avs_address == reset_flags_pkg::IRQ_STATUS_OFFSET && !(|events) |=>
      (st.status & $past(avs_writedata[5:0])) == 6'h00)
    else $error("status bit not cleared");

  irq_raise_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    events[reset_flags_pkg::EV_SERVICE] && st.mask[reset_flags_pkg::EV_SERVICE] && !wr |=>
      irq)
    else $error("unmasked event gave no interrupt");

  bidir_short_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    st.bidir && (software_reset_instruction || watchdog_reset_event) |=> short_hw_reset_flag)
    else $error("bidirectional option ignored for short flag");

  plain_long_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !st.bidir && (software_reset_instruction || watchdog_reset_event) && !long_pulse
      && !end_init_instruction |=> long_hw_reset_flag == $past(long_hw_reset_flag))
    else $error("long flag changed without option");
endmodule : reset_source_flags

// file: hdl/reset_flags_pkg.sv
// shared constants for the reset source indication block
package reset_flags_pkg;
  // ====================================================================
  // register map
  localparam logic [3:0] WATCHDOG_CONTROL_OFFSET = 4'h0;
  localparam logic [3:0] IRQ_STATUS_OFFSET       = 4'h4;
  localparam logic [3:0] IRQ_MASK_OFFSET         = 4'h8;
  localparam logic [3:0] OPTION_OFFSET           = 4'hC;
  // ====================================================================
  // field positions in the watchdog control register
  localparam int LONG_HW_POS   = 4;
  localparam int SHORT_HW_POS  = 3;
  localparam int SOFTWARE_POS  = 2;
  localparam int WATCHDOG_POS  = 1;
  // ====================================================================
  // event bits in status and mask
  localparam int EV_LONG_HW    = 0;
  localparam int EV_SHORT_HW   = 1;
  localparam int EV_SOFTWARE   = 2;
  localparam int EV_WATCHDOG   = 3;
  localparam int EV_END_INIT   = 4;
  localparam int EV_SERVICE    = 5;
  localparam int EV_WIDTH      = 6;
  // ====================================================================
  // reset values
  localparam logic [31:0] WATCHDOG_CONTROL_RESET = 32'h0000_0000;
  localparam logic [5:0]  IRQ_MASK_RESET         = 6'h00;
  localparam logic        BIDIR_RESET            = 1'b0;
endpackage : reset_flags_pkg

// file: hdl/pin_sync.sv
// two flip-flop synchroniser for one level input
`timescale 1ns/100ps
module pin_sync
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic pin,
  output logic      level
);
  logic first;
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      first <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      first <= pin;
      level <= first;
    end
  end
endmodule : pin_sync

// file: hdl/rise_detect.sv
// one-cycle pulse on rising edge of a synchronous level
`timescale 1ns/100ps
module rise_detect
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic level,
  output logic      pulse
);
  logic last;
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      last <= 1'b0;
    else
      last <= level;
  end
  assign pulse = level & ~last;
endmodule : rise_detect

// file: tb/reset_event_source.sv
// far-side model: reset pins and cpu instruction pulses
`timescale 1ns/100ps
module reset_event_source
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [2:0] kind,
  input  wire logic       fire,
  output logic            long_pin,
  output logic            short_pin,
  output logic [3:0]      pulse
);
  logic [2:0] hold;
  // ====================================================================
  // event generation
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold      <= 3'h0;
      long_pin  <= 1'b0;
      short_pin <= 1'b0;
      pulse     <= 4'h0;
    end
    else
    begin
      // instructions last exactly one cycle
      pulse <= (fire && kind >= 3'h2) ? 4'h1 << (kind - 3'h2) : 4'h0;
      // pins held long enough for the two-stage synchroniser
      if (fire && kind < 3'h2)
      begin
        hold      <= 3'h4;
        long_pin  <= (kind == 3'h0);
        short_pin <= (kind == 3'h1);
      end
      else if (hold != 3'h0)
        hold <= hold - 3'h1;
      else
      begin
        long_pin  <= 1'b0;
        short_pin <= 1'b0;
      end
    end
  end
endmodule : reset_event_source

// file: tb/tb_reset_source_flags.sv
// self-checking bench for the reset source flags block
`timescale 1ns/100ps
module tb_reset_source_flags;
  logic        clk_sys       = 1'b0;
  logic        reset_n       = 1'b0;
  logic [2:0]  kind          = 3'h0;
  logic        fire          = 1'b0;
  logic [3:0]  avs_address   = 4'h0;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic        long_pin;
  logic        short_pin;
  logic [3:0]  pulse;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  flags;
  logic        irq;
  logic [31:0] q;
  int          error_cnt     = 0;
  int          tests_run     = 0;
  int          cycles        = 0;

  always #4 clk_sys = ~clk_sys;

  reset_event_source src_u (.clk_sys(clk_sys), .reset_n(reset_n), .kind(kind), .fire(fire),
    .long_pin(long_pin), .short_pin(short_pin), .pulse(pulse));

  reset_source_flags dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .long_hw_reset_pin(long_pin),
    .short_hw_reset_pin(short_pin), .software_reset_instruction(pulse[0]),
    .watchdog_reset_event(pulse[1]), .end_init_instruction(pulse[2]),
    .watchdog_service_instruction(pulse[3]), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .long_hw_reset_flag(flags[3]),
    .short_hw_reset_flag(flags[2]), .software_reset_flag(flags[1]),
    .watchdog_reset_flag(flags[0]), .irq(irq));

  // ====================================================================
  // tasks
  task summarize();
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    // the answer is taken at the edge where waitrequest is sampled low; only the hang guard ends a wait
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task flg(input logic [31:0] exp);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(q, exp);
    chk({27'h000_0000, flags, 1'b0}, exp);
  endtask : flg

  task ev(input logic [2:0] k);
    @(posedge clk_sys);
    kind <= k;
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask : ev

  // ====================================================================
  // hang guard
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      error_cnt++;
      summarize();
    end
  end

  // ====================================================================
  // tests
  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    flg(32'h0000_0000);
    ev(3'h0);
    flg(32'h0000_001C);
    bus(1'b1, 4'h0, 32'hFFFF_FFFF);
    flg(32'h0000_001C);
    ev(3'h3);
    flg(32'h0000_001E);
    flg(32'h0000_001E);
    ev(3'h5);
    flg(32'h0000_001C);
    ev(3'h4);
    flg(32'h0000_0000);
    ev(3'h3);
    ev(3'h2);
    flg(32'h0000_0006);
    ev(3'h1);
    flg(32'h0000_000C);
    bus(1'b1, 4'hC, 32'h0000_0001);
    bus(1'b0, 4'hC, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    ev(3'h4);
    ev(3'h1);
    flg(32'h0000_001C);
    ev(3'h4);
    ev(3'h2);
    flg(32'h0000_001C);
    ev(3'h4);
    ev(3'h3);
    flg(32'h0000_001E);
    ev(3'h4);
    flg(32'h0000_0002);
    bus(1'b0, 4'h2, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    // interrupt: clear, raise masked, unmask, clear by writing one
    bus(1'b1, 4'h4, 32'h0000_003F);
    ev(3'h5);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(q, 32'h0000_0020);
    bus(1'b1, 4'h8, 32'h0000_0020);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(q, 32'h0000_0020);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    bus(1'b1, 4'h4, 32'h0000_0020);
    // the clear lands at the edge that ends the write, so look one edge later
    @(posedge clk_sys);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    summarize();
  end
endmodule : tb_reset_source_flags
